/* src/fbb_pkg.sv */
// Shared constants and carrier types for the buck-boost sequencer
package fbb_pkg;
   // Timing figures and LFSR seed
   localparam int unsigned CLK_HZ          = 40_000_000;
   localparam int unsigned DEAD_NS         = 50;
   localparam int unsigned DEAD_CYC        =
      ((DEAD_NS * (CLK_HZ / 1_000_000)) + 999) / 1000 < 1 ? 1 :
      ((DEAD_NS * (CLK_HZ / 1_000_000)) + 999) / 1000;
   localparam int unsigned UVLO_DLY_US     = 200;
   localparam int unsigned UVLO_DLY_CYC    =
      UVLO_DLY_US * (CLK_HZ / 1_000_000);
   localparam int unsigned PERIOD_DEF      = 100;
   localparam int unsigned MIN_ON_DEF      = 4;
   localparam int unsigned MIN_OFF_DEF     = 4;
   localparam int unsigned INIT_CYC        = 16;
   localparam int unsigned SLEEP_SPAN      = 16;
   localparam logic [7:0]  LFSR_SEED       = 8'hA5;

   typedef enum logic [1:0] {
      FBB_OP_BOOST,
      FBB_OP_BUCK,
      FBB_OP_BB
   } fbb_op_t;

   // Gate commands: bit set means switch conducting
   typedef struct packed {
      logic input_high_switch;
      logic input_low_switch;
      logic output_low_switch;
      logic output_high_switch;
   } fbb_gate_t;

   localparam fbb_gate_t GATE_OFF   = 4'h0;
   localparam fbb_gate_t GATE_S1    = 4'hA;
   localparam fbb_gate_t GATE_S2    = 4'h9;
   localparam fbb_gate_t GATE_S3    = 4'h5;
   localparam fbb_gate_t GATE_SLEEP = 4'h6;

   // Analog comparator events fed to the sequencer
   typedef struct packed {
      logic peak_current;
      logic below_skip_thr;
      logic vout_above_nom;
      logic vout_above_1pct;
      logic loop_demand;
   } fbb_sense_t;
endpackage : fbb_pkg

/* src/fbb_dead_time.sv */
// Dead-time inserter for one half bridge
`timescale 1ns/10ps
module fbb_dead_time #(
   parameter int unsigned DEAD = fbb_pkg::DEAD_CYC
) (
   input  wire logic ref_clk_i,
   input  wire logic arst_n_i,
   input  wire logic hi_req_i,
   input  wire logic lo_req_i,
   output logic      hi_o,
   output logic      lo_o
);
   localparam int unsigned CW = $clog2(DEAD + 1);
   logic [CW-1:0] cnt_r;
   logic          hi_r;
   logic          lo_r;
   logic          hi_want;
   logic          lo_want;

   // Conflicting requests resolve to both off
   assign hi_want = hi_req_i & ~lo_req_i;
   assign lo_want = lo_req_i & ~hi_req_i;

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         hi_r  <= 1'b0;
         lo_r  <= 1'b0;
         cnt_r <= '0;
      end else if ((hi_r && !hi_want) || (lo_r && !lo_want)) begin
         hi_r  <= 1'b0;
         lo_r  <= 1'b0;
         cnt_r <= CW'(DEAD);
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - 1'b1;
      end else begin
         hi_r <= hi_want;
         lo_r <= lo_want;
      end
   end

   assign hi_o = hi_r;
   assign lo_o = lo_r;
endmodule : fbb_dead_time

/* src/fbb_sequencer.sv */
// Four-switch buck-boost switching sequencer
`timescale 1ns/10ps
module fbb_sequencer #(
   parameter int unsigned PERIOD   = fbb_pkg::PERIOD_DEF,
   parameter int unsigned MIN_ON   = fbb_pkg::MIN_ON_DEF,
   parameter int unsigned MIN_OFF  = fbb_pkg::MIN_OFF_DEF,
   parameter int unsigned UVLO_DLY = fbb_pkg::UVLO_DLY_CYC,
   parameter int unsigned INIT_LEN = fbb_pkg::INIT_CYC
) (
   input  wire logic               ref_clk_i,
   input  wire logic               arst_n_i,
   input  wire logic               por_ok_i,
   input  wire logic               enable_undervoltage_input_i,
   input  wire logic               vin_in_range_i,
   input  wire logic               mode_select_i,
   input  wire logic               frequency_set_sync_i,
   input  wire logic               out_fault_i,
   input  wire fbb_pkg::fbb_sense_t sense_i,
   output fbb_pkg::fbb_gate_t      gate_o,
   output logic                    fault_flag_n_o,
   output logic                    fault_flag_n_oe_o,
   output logic                    neg_current_limit_o,
   output logic                    sleep_o,
   output logic                    running_o,
   output logic [1:0]              op_mode_o
);
   typedef enum logic [2:0] {
      FBB_OFF, FBB_INIT, FBB_STBY, FBB_S1, FBB_S2, FBB_S3, FBB_SKIP,
      FBB_SLEEP
   } fbb_seq_t;

   localparam int unsigned PW = $clog2(PERIOD + 1);
   localparam int unsigned UW = $clog2(UVLO_DLY + 1);
   localparam int unsigned IW = $clog2(INIT_LEN + 1);

   fbb_seq_t           st_r;
   fbb_seq_t           st_nxt;
   fbb_pkg::fbb_op_t   op_r;
   logic [PW-1:0]      ph_r;
   logic [PW-1:0]      on_r;
   logic [UW-1:0]      uv_r;
   logic [IW-1:0]      init_r;
   logic               init_done_r;
   logic               uv_trip_r;
   logic               neg_lim_r;
   logic [7:0]         lfsr_r;
   logic               flag_r;
   logic               tick;
   logic               skip_en;
   logic               run_ok;
   logic               sleep_cond;
   logic               vout_hi;
   fbb_pkg::fbb_gate_t gate_req;

   // Minimum on/off checks, used by several decisions
   function automatic logic on_ok(input logic [PW-1:0] t);
      on_ok = t >= PW'(MIN_ON);
   endfunction : on_ok

   function automatic logic off_ok(input logic [PW-1:0] t);
      off_ok = (PW'(PERIOD) - t) > PW'(MIN_OFF);
   endfunction : off_ok

   // Fixed-frequency internal clock tick
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) ph_r <= '0;
      else if (ph_r == PW'(PERIOD - 1)) ph_r <= '0;
      else ph_r <= ph_r + 1'b1;
   end
   assign tick = (ph_r == PW'(PERIOD - 1));

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         init_r      <= '0;
         init_done_r <= 1'b0;
      end else if (!por_ok_i) begin
         init_r      <= '0;
         init_done_r <= 1'b0;
      end else if (!init_done_r) begin
         init_r      <= init_r + 1'b1;
         init_done_r <= (init_r == IW'(INIT_LEN - 1));
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) neg_lim_r <= 1'b0;
      else if (por_ok_i && !init_done_r)
         neg_lim_r <= ~frequency_set_sync_i;
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         uv_r      <= '0;
         uv_trip_r <= 1'b1;
      end else if (enable_undervoltage_input_i) begin
         uv_r      <= '0;
         uv_trip_r <= 1'b0;
      end else if (uv_r == UW'(UVLO_DLY - 1)) begin
         uv_trip_r <= 1'b1;
      end else begin
         uv_r <= uv_r + 1'b1;
      end
   end

   assign run_ok = init_done_r & ~uv_trip_r & vin_in_range_i;

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) lfsr_r <= fbb_pkg::LFSR_SEED;
      else if (tick)
         lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4]
                    ^ lfsr_r[3]};
   end
   assign vout_hi = lfsr_r[0] ? sense_i.vout_above_1pct
                              : sense_i.vout_above_nom;

   assign skip_en = ~mode_select_i;
   assign sleep_cond = skip_en & sense_i.below_skip_thr & vout_hi
                       & (op_r != fbb_pkg::FBB_OP_BB);

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) op_r <= fbb_pkg::FBB_OP_BUCK;
      else if (tick && (st_r inside {FBB_S1, FBB_S2, FBB_S3})) begin
         case (op_r)
            fbb_pkg::FBB_OP_BUCK:
               if (!off_ok(on_r)) op_r <= fbb_pkg::FBB_OP_BB;
            fbb_pkg::FBB_OP_BOOST:
               if (!on_ok(on_r)) op_r <= fbb_pkg::FBB_OP_BB;
            fbb_pkg::FBB_OP_BB:
               if (on_r == '0) op_r <= fbb_pkg::FBB_OP_BOOST;
               else if (on_r >= PW'(PERIOD / 2))
                  op_r <= fbb_pkg::FBB_OP_BUCK;
            default: op_r <= fbb_pkg::FBB_OP_BUCK;
         endcase
      end
   end

   // On-time of the magnetising phase in the running cycle
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) on_r <= '0;
      else if (tick) on_r <= '0;
      else if (st_r == FBB_S1 || (op_r == fbb_pkg::FBB_OP_BUCK
               && st_r == FBB_S2))
         on_r <= on_r + 1'b1;
   end

   always_comb begin
      st_nxt = st_r;
      case (st_r)
         FBB_OFF:  if (por_ok_i) st_nxt = FBB_INIT;
         FBB_INIT: if (init_done_r) st_nxt = FBB_STBY;
         FBB_STBY: if (run_ok && tick)
                      st_nxt = (op_r == fbb_pkg::FBB_OP_BUCK) ? FBB_S2
                                                             : FBB_S1;
         FBB_S1: if (tick) st_nxt = FBB_S1;
                 else if (on_ok(on_r) && (sense_i.peak_current
                          || !off_ok(on_r)))
                    st_nxt = FBB_S2;
         FBB_S2: if (tick)
                    st_nxt = (op_r == fbb_pkg::FBB_OP_BUCK) ? FBB_S2
                                                           : FBB_S1;
                 else if (op_r != fbb_pkg::FBB_OP_BOOST
                          && sense_i.peak_current && on_ok(on_r))
                    st_nxt = FBB_S3;
         FBB_S3: if (tick)
                    st_nxt = (op_r == fbb_pkg::FBB_OP_BUCK) ? FBB_S2
                                                           : FBB_S1;
         FBB_SKIP: if (tick && sense_i.loop_demand)
                      st_nxt = FBB_S1;
         FBB_SLEEP: if (!sense_i.vout_above_nom) st_nxt = FBB_STBY;
         default: st_nxt = FBB_OFF;
      endcase
      if (st_r inside {FBB_S1, FBB_S2, FBB_S3} && tick && skip_en) begin
         if (sleep_cond) st_nxt = FBB_SLEEP;
         else if (op_r == fbb_pkg::FBB_OP_BB && !sense_i.loop_demand)
            st_nxt = FBB_SKIP;
      end
      if (!por_ok_i) st_nxt = FBB_OFF;
      else if (st_r != FBB_OFF && st_r != FBB_INIT && !run_ok)
         st_nxt = FBB_STBY;
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) st_r <= FBB_OFF;
      else st_r <= st_nxt;
   end

   always_comb begin
      case (st_r)
         FBB_S1:    gate_req = fbb_pkg::GATE_S1;
         FBB_S2:    gate_req = fbb_pkg::GATE_S2;
         FBB_S3:    gate_req = fbb_pkg::GATE_S3;
         FBB_SLEEP: gate_req = fbb_pkg::GATE_SLEEP;
         default:   gate_req = fbb_pkg::GATE_OFF;
      endcase
   end

   fbb_dead_time u_dt_in (
      .ref_clk_i (ref_clk_i),
      .arst_n_i  (arst_n_i),
      .hi_req_i  (gate_req.input_high_switch),
      .lo_req_i  (gate_req.input_low_switch),
      .hi_o      (gate_o.input_high_switch),
      .lo_o      (gate_o.input_low_switch)
   );

   fbb_dead_time u_dt_out (
      .ref_clk_i (ref_clk_i),
      .arst_n_i  (arst_n_i),
      .hi_req_i  (gate_req.output_high_switch),
      .lo_req_i  (gate_req.output_low_switch),
      .hi_o      (gate_o.output_high_switch),
      .lo_o      (gate_o.output_low_switch)
   );

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) flag_r <= 1'b0;
      else flag_r <= out_fault_i;
   end
   assign fault_flag_n_o    = 1'b0;
   assign fault_flag_n_oe_o = flag_r;

   assign neg_current_limit_o = neg_lim_r;
   assign sleep_o             = (st_r == FBB_SLEEP);
   assign running_o           = run_ok;
   assign op_mode_o           = op_r;
endmodule : fbb_sequencer

/* verification/fbb_seq_props.sv */
// Port checker for the buck-boost sequencer
`timescale 1ns/10ps
module fbb_seq_props #(
   parameter int unsigned UVLO_DLY = 20
) (
   input wire logic                ref_clk_i,
   input wire logic                arst_n_i,
   input wire logic                enable_undervoltage_input_i,
   input wire logic                vin_in_range_i,
   input wire logic                mode_select_i,
   input wire logic                out_fault_i,
   input wire fbb_pkg::fbb_sense_t sense_i,
   input wire fbb_pkg::fbb_gate_t  gate_o,
   input wire logic                fault_flag_n_o,
   input wire logic                fault_flag_n_oe_o,
   input wire logic                sleep_o,
   input wire logic                running_o,
   input wire logic [1:0]          op_mode_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!arst_n_i);
   logic [15:0] low_cnt_r;
   // Saturates so a long shutdown never wraps
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i)
         low_cnt_r <= 16'h0000;
      else if (enable_undervoltage_input_i)
         low_cnt_r <= 16'h0000;
      else if (low_cnt_r != 16'hFFFF)
         low_cnt_r <= low_cnt_r + 16'h0001;
   end
   sequence s_in_lo_off; !gate_o.input_low_switch [*3]; endsequence
   sequence s_out_hi_off; !gate_o.output_high_switch [*3]; endsequence
   property p_in_pair;
      !(gate_o.input_high_switch && gate_o.input_low_switch);
   endproperty
   property p_out_pair;
      !(gate_o.output_low_switch && gate_o.output_high_switch);
   endproperty
   property p_in_dead; $fell(gate_o.input_high_switch) |-> s_in_lo_off;
   endproperty
   property p_out_dead; $fell(gate_o.output_low_switch) |-> s_out_hi_off;
   endproperty
   property p_idle_off;
      (!running_o && !sleep_o) [*4] |-> gate_o == fbb_pkg::GATE_OFF;
   endproperty
   property p_fault; $changed(out_fault_i) |=>
      fault_flag_n_oe_o == $past(out_fault_i) && fault_flag_n_o == 1'b0;
   endproperty
   property p_sleep; sleep_o [*5] |-> gate_o == fbb_pkg::GATE_SLEEP;
   endproperty
   property p_vin_block; !vin_in_range_i |-> !running_o; endproperty
   property p_buck_peak; running_o && mode_select_i && op_mode_o == 2'h1
      && gate_o == fbb_pkg::GATE_S2 && sense_i.peak_current
      |-> ##[1:7] !gate_o.input_high_switch;
   endproperty
   property p_uvlo; low_cnt_r >= 16'(UVLO_DLY) |-> !running_o;
   endproperty
   a_in_pair: assert property (p_in_pair)
      else $error("input bridge both on");
   a_out_pair: assert property (p_out_pair)
      else $error("output bridge both on");
   a_in_dead: assert property (p_in_dead)
      else $error("input bridge dead time short");
   a_out_dead: assert property (p_out_dead)
      else $error("output bridge dead time short");
   a_idle_off: assert property (p_idle_off)
      else $error("switch on while stopped");
   a_fault: assert property (p_fault)
      else $error("fault flag does not follow fault");
   a_sleep: assert property (p_sleep)
      else $error("sleep without both low sides on");
   a_vin_block: assert property (p_vin_block)
      else $error("running with input out of range");
   a_buck_peak: assert property (p_buck_peak)
      else $error("buck peak did not end state two");
   a_uvlo: assert property (p_uvlo)
      else $error("running after undervoltage delay");
endmodule : fbb_seq_props
bind fbb_sequencer fbb_seq_props #(.UVLO_DLY(UVLO_DLY)) props_u (
   .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
   .enable_undervoltage_input_i(enable_undervoltage_input_i),
   .vin_in_range_i(vin_in_range_i), .mode_select_i(mode_select_i),
   .out_fault_i(out_fault_i), .sense_i(sense_i), .gate_o(gate_o),
   .fault_flag_n_o(fault_flag_n_o), .fault_flag_n_oe_o(fault_flag_n_oe_o),
   .sleep_o(sleep_o), .running_o(running_o), .op_mode_o(op_mode_o));

/* verification/fbb_stage_model.sv */
// Power stage stand-in: inductor current ramp with peak detect
`timescale 1ns/10ps
module fbb_stage_model (
   input  wire logic               ref_clk_i,
   input  wire logic               arst_n_i,
   input  wire fbb_pkg::fbb_gate_t gate_i,
   input  wire logic [7:0]         peak_thr_i,
   output logic                    peak_o
);
   logic [7:0] cur_r;
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i)
         cur_r <= 8'h00;
      else if (gate_i.input_low_switch || gate_i == 4'h0)
         cur_r <= 8'h00;
      else if (gate_i.input_high_switch && cur_r != 8'hFF)
         cur_r <= cur_r + 8'h01;
   end
   assign peak_o = (cur_r >= peak_thr_i);
endmodule : fbb_stage_model

/* verification/four_switch_buck_boost_sequencer_tb.sv */
// Random and corner-case bench for the buck-boost sequencer
`timescale 1ns/10ps
module four_switch_buck_boost_sequencer_tb;
   localparam int unsigned UVLO = 20;
   // Gate patterns {in_hi, in_lo, out_lo, out_hi}
   localparam logic [3:0] ST1 = 4'hA;
   localparam logic [3:0] ST2 = 4'h9;
   localparam logic [3:0] ST3 = 4'h5;
   localparam logic [3:0] SLP = 4'h6;
   logic clk = 1'b0, arst_n = 1'b0, por = 1'b0, en = 1'b1, input_supply = 1'b1;
   logic mode = 1'b1, sync = 1'b0, fault = 1'b0, peak;
   logic [3:0] sn = 4'h0;
   logic [7:0] thr = 8'h14;
   logic flag_n, flag_oe, neg_lim, sleep, run, slp_seen;
   logic [1:0] op;
   logic [15:0] seen;
   logic [3:0] op_seen;
   fbb_pkg::fbb_gate_t gate;
   int errors = 0;
   int checks_done = 0;
   int cyc = 0;
   initial forever #12.5 clk = ~clk;
   fbb_sequencer #(.UVLO_DLY(UVLO)) dut_u (
      .ref_clk_i(clk), .arst_n_i(arst_n), .por_ok_i(por),
      .enable_undervoltage_input_i(en), .vin_in_range_i(input_supply),
      .mode_select_i(mode), .frequency_set_sync_i(sync),
      .out_fault_i(fault), .sense_i(fbb_pkg::fbb_sense_t'({peak, sn})),
      .gate_o(gate), .fault_flag_n_o(flag_n), .fault_flag_n_oe_o(flag_oe),
      .neg_current_limit_o(neg_lim), .sleep_o(sleep), .running_o(run),
      .op_mode_o(op));
   fbb_stage_model stage_u (.ref_clk_i(clk), .arst_n_i(arst_n),
      .gate_i(gate), .peak_thr_i(thr), .peak_o(peak));
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask : step
   task automatic run_for(input int n);
      seen = 16'h0000;
      op_seen = 4'h0;
      slp_seen = 1'b0;
      repeat (n) begin
         step(1);
         seen[gate] = 1'b1;
         op_seen[op] = 1'b1;
         slp_seen |= sleep;
      end
      check({7'h00, |(seen & 16'hF888)}, 8'h00);
   endtask : run_for
   task automatic boot(input logic s);
      arst_n = 1'b0;
      por = 1'b0;
      sync = s;
      step(2);
      check(8'(gate), 8'h00);
      check(8'(op), 8'h01);
      arst_n = 1'b1;
      step(1);
      por = 1'b1;
      step(24);
      sync = ~s;
      for (int i = 0; i < 400 && run !== 1'b1; i++) step(1);
      check({7'h00, run}, 8'h01);
      check({7'h00, neg_lim}, {7'h00, ~s});
   endtask : boot
   task automatic complete_run;
      $display("checks_done=%0d errors=%0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : complete_run
   // Cuts a hang short well beyond the expected run length
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         complete_run();
      end
   end
   initial begin
      void'($urandom(57));
      boot(1'b0);
      boot(1'b1);
      run_for(300);
      check({7'h00, seen[ST2] & seen[ST3]}, 8'h01);
      check(8'(op), 8'h01);
      thr = 8'h61;
      run_for(600);
      check({7'h00, op_seen[2]}, 8'h01);
      check({7'h00, seen[ST1] & seen[ST3]}, 8'h01);
      repeat (6) begin
         thr = 8'($urandom_range(8, 90));
         sn = 4'($urandom_range(0, 15));
         run_for(200);
         check({7'h00, slp_seen}, 8'h00);
      end
      thr = 8'h14;
      sn = 4'hE;
      // Restart in buck so sleep entry is reachable
      boot(1'b1);
      mode = 1'b0;
      for (int i = 0; i < 1000 && sleep !== 1'b1; i++) step(1);
      check({7'h00, sleep}, 8'h01);
      step(6);
      check(8'(gate), {4'h0, SLP});
      sn = 4'h8;
      for (int i = 0; i < 300 && sleep !== 1'b0; i++) step(1);
      check({7'h00, sleep}, 8'h00);
      mode = 1'b1;
      fault = 1'b1;
      step(2);
      check({6'h00, flag_oe, flag_n}, 8'h02);
      fault = 1'b0;
      step(2);
      check({6'h00, flag_oe, flag_n}, 8'h00);
      input_supply = 1'b0;
      step(8);
      check({3'h0, run, gate}, 8'h00);
      input_supply = 1'b1;
      step(50);
      en = 1'b0;
      step(UVLO / 2);
      check({7'h00, run}, 8'h01);
      en = 1'b1;
      step(4);
      en = 1'b0;
      step(UVLO + 8);
      check({3'h0, run, gate}, 8'h00);
      complete_run();
   end
endmodule : four_switch_buck_boost_sequencer_tb
